// File: verilog/pmc_pkg.sv
// Package of register map, field positions, reset values and timing counts for the power mode control block
// Overview of operation
// R1 - Sleep instruction, standby off, active: sleep
// R2 - Sleep instruction, standby off, subactive: subsleep
// R3 - Standby on: active to standby/watch, subactive to watch
// R4 - Active with standby on: watch if timer-A bit
// R5 - Subclock divider: 00 /8, 01 /4, 1x /2
// R6 - Medium speed flag 0: resume high speed
// R7 - Medium speed flag 1: resume medium speed
// R8 - Sleep speed follows medium speed flag
// R9 - Direct: high to medium speed
// R10 - Direct: active to subactive
// R11 - Direct: medium to high speed
// R12 - Direct: subactive to high or medium speed
// R13 - Direct off: ordinary transitions only
// R14 - Noise sampling: oscillator /16 or /4
// R15 - Request line 3 edge select
// R16 - Wakeup line 7 and timer Y edge select
// R17 - Timer B1 interrupt enable gates requests
// R18 - Port 5 pull-up register, eight bits, reset 0
// R19 - Direct transfer flag set, cleared writing 0
// R20 - Direct transfer interrupt enable gates requests
// R21 - Standby/watch exit waits selected state count
package pmc_pkg;
	// ************************************************
	// Register map (byte addresses)
	// ************************************************
	localparam logic [11:0] PMC_ADDR_PULLUP5 = 12'h000;
	localparam logic [11:0] PMC_ADDR_SYSCTL1 = 12'h004;
	localparam logic [11:0] PMC_ADDR_SYSCTL2 = 12'h008;
	localparam logic [11:0] PMC_ADDR_EDGE    = 12'h00c;
	localparam logic [11:0] PMC_ADDR_IRQEN   = 12'h010;
	localparam logic [11:0] PMC_ADDR_FLAG    = 12'h014;
	localparam logic [11:0] PMC_ADDR_MODE    = 12'h018;
	// ************************************************
	// Field positions
	// ************************************************
	localparam int PMC_SC1_SOFT_STANDBY_SELECT = 7;
	localparam int PMC_SC1_STS  = 4;
	localparam int PMC_SC1_LOW_SPEED_ON = 3;
	localparam int PMC_SC2_NES  = 4;
	localparam int PMC_SC2_DT   = 3;
	localparam int PMC_SC2_MS   = 2;
	localparam int PMC_EDGE_L3  = 0;
	localparam int PMC_EDGE_L7  = 1;
	localparam int PMC_IEN_TB1  = 0;
	localparam int PMC_IEN_DT   = 1;
	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] PMC_RST_PULLUP5 = 8'h00;
	localparam logic [7:0] PMC_RST_SYSCTL1 = 8'h07;
	localparam logic [7:0] PMC_RST_SYSCTL2 = 8'he0;
	localparam logic [7:0] PMC_SC1_RO_MASK = 8'h04;
	localparam logic [7:0] PMC_SC2_RO_MASK = 8'he0;
	// ************************************************
	// Timing counts (states of the system clock)
	// ************************************************
	localparam int PMC_WAIT_0 = 8192;
	localparam int PMC_WAIT_1 = 16384;
	localparam int PMC_WAIT_2 = 32768;
	localparam int PMC_WAIT_3 = 65536;
	localparam int PMC_WAIT_4 = 131072;
	localparam int PMC_NS_SLOW = 16;
	localparam int PMC_NS_FAST = 4;
	// Power modes
	typedef enum logic [2:0] {
		PMC_HIGH, PMC_MEDIUM, PMC_SUBACT, PMC_SLEEP, PMC_SUBSLEEP, PMC_STANDBY, PMC_WATCH
	} pmc_mode_type;
endpackage

// File: verilog/pmc_ctl_if.sv
// Interface carrying control settings from the top to the pin sampler
`timescale 1ns/1ps
interface pmc_ctl_if;
	logic       ns_fast;
	logic       edge3_rise;
	logic       edge7_rise;
	logic       det3;
	logic       det7;
	logic       dety;
	modport ctl (output ns_fast, output edge3_rise, output edge7_rise, input det3, input det7, input dety);
	modport smp (input ns_fast, input edge3_rise, input edge7_rise, output det3, output det7, output dety);
endinterface

// File: verilog/pmc_pin_edge.sv
// Synchronising, noise-sampling edge detector for the external request pins
`timescale 1ns/1ps
module pmc_pin_edge (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rstn_in,
	// Pins
	input  wire logic line3_in,
	input  wire logic line7_in,
	input  wire logic tmy_in,
	// Control
	pmc_ctl_if.smp    ctl
);
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] smp_reg;
	logic [4:0] div_reg;
	logic       tick;
	logic [2:0] rise;
	// ************************************************
	// Two-flop synchronisers
	// ************************************************
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_reg <= 3'h7;
			s2_reg <= 3'h7;
		end else begin
			s1_reg <= {tmy_in, line7_in, line3_in};
			s2_reg <= s1_reg;
		end
	end
	// Sampling divider; slower rate rejects short glitches
	assign tick = (ctl.ns_fast) ? (div_reg >= 5'(pmc_pkg::PMC_NS_FAST - 1)) :
		(div_reg >= 5'(pmc_pkg::PMC_NS_SLOW - 1)); // R14
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			div_reg <= 5'h00;
		else if (tick)
			div_reg <= 5'h00;
		else
			div_reg <= div_reg + 5'h01;
	end
	// Sampled level register
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			smp_reg <= 3'h7;
		else if (tick)
			smp_reg <= s2_reg;
	end
	assign rise = s2_reg & ~smp_reg;
	// Edge select per line; fall is the default after reset
	assign ctl.det3 = tick & (ctl.edge3_rise ? rise[0] : (smp_reg[0] & ~s2_reg[0])); // R15
	assign ctl.det7 = tick & (ctl.edge7_rise ? rise[1] : (smp_reg[1] & ~s2_reg[1])); // R16
	assign ctl.dety = tick & (ctl.edge7_rise ? rise[2] : (smp_reg[2] & ~s2_reg[2])); // R16
endmodule // pmc_pin_edge

// File: verilog/pmc_top.sv
// Power mode control: APB registers, sleep-instruction mode selection, wake wait and interrupt gating
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module pmc_top #(
	parameter int WAIT_0 = pmc_pkg::PMC_WAIT_0,
	parameter int WAIT_1 = pmc_pkg::PMC_WAIT_1,
	parameter int WAIT_2 = pmc_pkg::PMC_WAIT_2,
	parameter int WAIT_3 = pmc_pkg::PMC_WAIT_3,
	parameter int WAIT_4 = pmc_pkg::PMC_WAIT_4
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Core events
	input  wire logic        sleep_in,
	input  wire logic        wake_in,
	input  wire logic        timer_a_src_in,
	input  wire logic        tb1_req_in,
	// Pins
	input  wire logic        line3_in,
	input  wire logic        line7_in,
	input  wire logic        tmy_in,
	// Outputs
	output logic      [2:0]  mode_out,
	output logic             cpu_run_out,
	output logic             sub_tick_out,
	output logic      [7:0]  pullup5_out,
	output logic             tb1_irq_out,
	output logic             dt_irq_out,
	output logic             line3_evt_out,
	output logic             line7_evt_out,
	output logic             tmy_evt_out
);
	pmc_ctl_if ctl_bus ();
	pmc_pkg::pmc_mode_type mode_reg;
	pmc_pkg::pmc_mode_type mode_next;
	logic [7:0]  pull_reg;
	logic [7:0]  sc1_reg;
	logic [7:0]  sc2_reg;
	logic [1:0]  edge_reg;
	logic [1:0]  ien_reg;
	logic        dtf_reg;
	logic [17:0] wait_reg;
	logic [17:0] wait_load;
	logic [2:0]  subdiv_reg;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        is_direct;
	logic        soft_standby_select;
	logic        low_speed_on;
	logic        medium_speed_on;
	logic        direct_transfer_on;
	logic [2:0]  sub_lim;
	assign soft_standby_select = sc1_reg[pmc_pkg::PMC_SC1_SOFT_STANDBY_SELECT];
	assign low_speed_on = sc1_reg[pmc_pkg::PMC_SC1_LOW_SPEED_ON];
	assign medium_speed_on = sc2_reg[pmc_pkg::PMC_SC2_MS];
	assign direct_transfer_on = sc2_reg[pmc_pkg::PMC_SC2_DT];

	// ************************************************
	// APB slave
	// ************************************************
	// Zero-wait slave: every access completes in its first access cycle
	assign pready_out = 1'b1;
	assign addr_ok = (paddr_in == pmc_pkg::PMC_ADDR_PULLUP5) | (paddr_in == pmc_pkg::PMC_ADDR_SYSCTL1) |
		(paddr_in == pmc_pkg::PMC_ADDR_SYSCTL2) | (paddr_in == pmc_pkg::PMC_ADDR_EDGE) |
		(paddr_in == pmc_pkg::PMC_ADDR_IRQEN) | (paddr_in == pmc_pkg::PMC_ADDR_FLAG) |
		(paddr_in == pmc_pkg::PMC_ADDR_MODE);
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign wr_en = psel_in & penable_in & pwrite_in & addr_ok;
	assign rd_en = psel_in & ~penable_in & ~pwrite_in;
	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			prdata_out <= 32'h0000_0000;
		else if (rd_en) begin
			case (paddr_in)
				pmc_pkg::PMC_ADDR_PULLUP5: prdata_out <= {24'h00_0000, pull_reg};
				pmc_pkg::PMC_ADDR_SYSCTL1: prdata_out <= {24'h00_0000, sc1_reg};
				pmc_pkg::PMC_ADDR_SYSCTL2: prdata_out <= {24'h00_0000, sc2_reg};
				pmc_pkg::PMC_ADDR_EDGE:    prdata_out <= {30'h0, edge_reg};
				pmc_pkg::PMC_ADDR_IRQEN:   prdata_out <= {30'h0, ien_reg};
				pmc_pkg::PMC_ADDR_FLAG:    prdata_out <= {31'h0, dtf_reg};
				pmc_pkg::PMC_ADDR_MODE:    prdata_out <= {28'h000_0000, ~cpu_run_out, mode_reg};
				default:                   prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************
	// Control registers
	// ************************************************
	// Port 5 pull-up control, plain read/write
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			pull_reg <= pmc_pkg::PMC_RST_PULLUP5; // R18
		else if (wr_en && paddr_in == pmc_pkg::PMC_ADDR_PULLUP5)
			pull_reg <= pwdata_in[7:0]; // R18
	end
	assign pullup5_out = pull_reg;
	// System control one and two; SYSCTL1 bit 2 and SYSCTL2 bits 7:5 hold their fixed ones, SYSCTL1 bits 1:0 take the written value
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sc1_reg <= pmc_pkg::PMC_RST_SYSCTL1;
			sc2_reg <= pmc_pkg::PMC_RST_SYSCTL2;
		end else if (wr_en) begin
			if (paddr_in == pmc_pkg::PMC_ADDR_SYSCTL1)
				sc1_reg <= (pwdata_in[7:0] & ~pmc_pkg::PMC_SC1_RO_MASK) | pmc_pkg::PMC_SC1_RO_MASK;
			if (paddr_in == pmc_pkg::PMC_ADDR_SYSCTL2)
				sc2_reg <= (pwdata_in[7:0] & ~pmc_pkg::PMC_SC2_RO_MASK) | pmc_pkg::PMC_SC2_RO_MASK;
		end
	end
	// Edge select and interrupt enables
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			edge_reg <= 2'h0;
			ien_reg  <= 2'h0;
		end else if (wr_en) begin
			if (paddr_in == pmc_pkg::PMC_ADDR_EDGE)
				edge_reg <= pwdata_in[1:0];
			if (paddr_in == pmc_pkg::PMC_ADDR_IRQEN)
				ien_reg <= pwdata_in[1:0];
		end
	end

	// ************************************************
	// Mode selection on a sleep instruction or a wake event
	// ************************************************
	always_comb begin
		mode_next = mode_reg;
		is_direct = 1'b0;
		case (mode_reg)
			pmc_pkg::PMC_HIGH, pmc_pkg::PMC_MEDIUM: begin
				if (sleep_in) begin
					if (direct_transfer_on && !soft_standby_select && medium_speed_on && !low_speed_on && mode_reg == pmc_pkg::PMC_HIGH) begin
						mode_next = pmc_pkg::PMC_MEDIUM; // R9
						is_direct = 1'b1;
					end else if (direct_transfer_on && !soft_standby_select && !medium_speed_on && !low_speed_on && mode_reg == pmc_pkg::PMC_MEDIUM) begin
						mode_next = pmc_pkg::PMC_HIGH; // R11
						is_direct = 1'b1;
					end else if (direct_transfer_on && soft_standby_select && timer_a_src_in && low_speed_on) begin
						mode_next = pmc_pkg::PMC_SUBACT; // R10
						is_direct = 1'b1;
					end else if (!soft_standby_select)
						mode_next = pmc_pkg::PMC_SLEEP; // R1 R8 R13
					else if (timer_a_src_in)
						mode_next = pmc_pkg::PMC_WATCH; // R3 R4
					else
						mode_next = pmc_pkg::PMC_STANDBY; // R3 R4
				end
			end
			pmc_pkg::PMC_SUBACT: begin
				if (sleep_in) begin
					if (direct_transfer_on && soft_standby_select && timer_a_src_in && !low_speed_on) begin
						mode_next = medium_speed_on ? pmc_pkg::PMC_MEDIUM : pmc_pkg::PMC_HIGH; // R12
						is_direct = 1'b1;
					end else if (!soft_standby_select)
						mode_next = pmc_pkg::PMC_SUBSLEEP; // R2 R13
					else
						mode_next = pmc_pkg::PMC_WATCH; // R3 R13
				end
			end
			pmc_pkg::PMC_SLEEP: begin
				if (wake_in)
					mode_next = medium_speed_on ? pmc_pkg::PMC_MEDIUM : pmc_pkg::PMC_HIGH; // R6 R7
			end
			pmc_pkg::PMC_SUBSLEEP: begin
				if (wake_in)
					mode_next = pmc_pkg::PMC_SUBACT;
			end
			pmc_pkg::PMC_STANDBY, pmc_pkg::PMC_WATCH: begin
				if (wake_in && wait_reg == 18'h0_0000)
					mode_next = medium_speed_on ? pmc_pkg::PMC_MEDIUM : pmc_pkg::PMC_HIGH; // R6 R7 R21
			end
			default: mode_next = pmc_pkg::PMC_HIGH;
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			mode_reg <= pmc_pkg::PMC_HIGH;
		else
			mode_reg <= mode_next;
	end
	assign mode_out = mode_reg;

	// ************************************************
	// Wake wait counter
	// ************************************************
	// Loaded on entry so the oscillator has settled before the CPU restarts
	always_comb begin
		case (sc1_reg[6:4])
			3'h0:    wait_load = 18'(WAIT_0 - 1);
			3'h1:    wait_load = 18'(WAIT_1 - 1);
			3'h2:    wait_load = 18'(WAIT_2 - 1);
			3'h3:    wait_load = 18'(WAIT_3 - 1);
			default: wait_load = 18'(WAIT_4 - 1);
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			wait_reg <= 18'h0_0000;
		else if ((mode_next == pmc_pkg::PMC_STANDBY || mode_next == pmc_pkg::PMC_WATCH) &&
			mode_reg != mode_next)
			wait_reg <= wait_load; // R21
		else if (wake_in && wait_reg != 18'h0_0000)
			wait_reg <= wait_reg - 18'h0_0001; // R21
	end
	assign cpu_run_out = (mode_reg == pmc_pkg::PMC_HIGH) || (mode_reg == pmc_pkg::PMC_MEDIUM) ||
		(mode_reg == pmc_pkg::PMC_SUBACT);

	// ************************************************
	// Subactive clock divider
	// ************************************************
	assign sub_lim = sc2_reg[1] ? 3'h1 : (sc2_reg[0] ? 3'h3 : 3'h7); // R5
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			subdiv_reg <= 3'h0;
		else if (subdiv_reg >= sub_lim)
			subdiv_reg <= 3'h0;
		else
			subdiv_reg <= subdiv_reg + 3'h1;
	end
	assign sub_tick_out = (subdiv_reg >= sub_lim) && (mode_reg == pmc_pkg::PMC_SUBACT); // R5

	// ************************************************
	// Direct transfer flag and interrupts
	// ************************************************
	// Set wins over a concurrent write of zero
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in)
			dtf_reg <= 1'b0;
		else if (is_direct)
			dtf_reg <= 1'b1; // R19
		else if (wr_en && paddr_in == pmc_pkg::PMC_ADDR_FLAG && !pwdata_in[0])
			dtf_reg <= 1'b0; // R19
	end
	assign dt_irq_out  = dtf_reg & ien_reg[pmc_pkg::PMC_IEN_DT]; // R20
	assign tb1_irq_out = tb1_req_in & ien_reg[pmc_pkg::PMC_IEN_TB1]; // R17

	// ************************************************
	// Pin edge detection
	// ************************************************
	assign ctl_bus.ns_fast    = sc2_reg[pmc_pkg::PMC_SC2_NES]; // R14
	assign ctl_bus.edge3_rise = edge_reg[pmc_pkg::PMC_EDGE_L3]; // R15
	assign ctl_bus.edge7_rise = edge_reg[pmc_pkg::PMC_EDGE_L7]; // R16
	pmc_pin_edge u_edge (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.line3_in   (line3_in),
		.line7_in   (line7_in),
		.tmy_in     (tmy_in),
		.ctl        (ctl_bus.smp)
	);
	assign line3_evt_out = ctl_bus.det3;
	assign line7_evt_out = ctl_bus.det7;
	assign tmy_evt_out   = ctl_bus.dety;

	// ************************************************
	// Checks
	// ************************************************
	sequence s_direct_sleep;
		sleep_in && direct_transfer_on && cpu_run_out;
	endsequence

	a_pullup_reset: assert property (@(posedge clk_sys_in) $rose(rstn_in) |-> pull_reg == 8'h00) // R18
		else $error("pull-up register not zero after reset");

	a_sleep_entry: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_reg == pmc_pkg::PMC_HIGH && sleep_in && !soft_standby_select && !direct_transfer_on) |=> mode_reg == pmc_pkg::PMC_SLEEP) // R1
		else $error("active sleep did not enter sleep");

	a_subsleep_entry: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_reg == pmc_pkg::PMC_SUBACT && sleep_in && !soft_standby_select) |=> mode_reg == pmc_pkg::PMC_SUBSLEEP) // R2
		else $error("subactive sleep did not enter subsleep");

	a_watch_pick: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_reg == pmc_pkg::PMC_HIGH && sleep_in && soft_standby_select && !direct_transfer_on) |=>
		mode_reg == ($past(timer_a_src_in) ? pmc_pkg::PMC_WATCH : pmc_pkg::PMC_STANDBY)) // R4
		else $error("wrong standby or watch choice");

	a_flag_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		is_direct |=> dtf_reg) // R19
		else $error("direct transfer flag not set");

	a_direct_seq: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		s_direct_sleep ##1 (mode_reg != $past(mode_reg) && cpu_run_out) |-> dtf_reg ##1 dtf_reg || !$past(is_direct)) // R10
		else $error("direct move lost its flag");

	a_dt_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		dt_irq_out == (dtf_reg && ien_reg[1])) // R20
		else $error("direct transfer interrupt gating wrong");

	a_tb1_gate: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!ien_reg[0] |-> !tb1_irq_out) // R17
		else $error("timer B1 request not blocked");

	a_wake_wait: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(mode_reg == pmc_pkg::PMC_STANDBY && wait_reg != 18'h0_0000) |=> !cpu_run_out) // R21
		else $error("woke before wait ended");

	a_sub_div: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(sc2_reg[1:0] == 2'h0 && subdiv_reg == 3'h0) ##1 (sc2_reg[1:0] == 2'h0)[*7] |-> subdiv_reg == 3'h7) // R5
		else $error("subclock divide by eight wrong");

	// Direct moves and exits, one property for each direct move, then further rule checks
	a_medium_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R9
		(mode_reg == pmc_pkg::PMC_HIGH && sleep_in && direct_transfer_on && !soft_standby_select && medium_speed_on && !low_speed_on) |=>
		mode_reg == pmc_pkg::PMC_MEDIUM) else $error("direct move to medium speed missed");

	a_high_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R11
		(mode_reg == pmc_pkg::PMC_MEDIUM && sleep_in && direct_transfer_on && !soft_standby_select && !medium_speed_on && !low_speed_on) |=>
		mode_reg == pmc_pkg::PMC_HIGH) else $error("direct move to high speed missed");

	a_sub_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R10
		(cpu_run_out && mode_reg != pmc_pkg::PMC_SUBACT && sleep_in && direct_transfer_on && soft_standby_select && timer_a_src_in && low_speed_on) |=>
		mode_reg == pmc_pkg::PMC_SUBACT) else $error("direct move to subactive missed");

	a_sub_exit: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R12
		(mode_reg == pmc_pkg::PMC_SUBACT && sleep_in && direct_transfer_on && soft_standby_select && timer_a_src_in && !low_speed_on) |=>
		mode_reg == ($past(medium_speed_on) ? pmc_pkg::PMC_MEDIUM : pmc_pkg::PMC_HIGH))
		else $error("direct move from subactive wrong");

	a_sleep_wake: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R6 R7
		(mode_reg == pmc_pkg::PMC_SLEEP && wake_in) |=>
		mode_reg == ($past(medium_speed_on) ? pmc_pkg::PMC_MEDIUM : pmc_pkg::PMC_HIGH))
		else $error("sleep exit speed wrong");

	a_no_direct: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R13
		(cpu_run_out && sleep_in && !direct_transfer_on) |=> !cpu_run_out)
		else $error("sleep without direct transfer kept the CPU running");

	a_flag_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R19
		(wr_en && paddr_in == pmc_pkg::PMC_ADDR_FLAG && !pwdata_in[0] && !is_direct) |=> !dtf_reg)
		else $error("direct transfer flag not cleared");

	a_pull_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R18
		(wr_en && paddr_in == pmc_pkg::PMC_ADDR_PULLUP5) |=> pull_reg == $past(pwdata_in[7:0]))
		else $error("pull-up write did not land");

	a_tb1_pass: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // R17
		(ien_reg[pmc_pkg::PMC_IEN_TB1] && tb1_req_in) |-> tb1_irq_out)
		else $error("timer B1 request not passed on");
endmodule // pmc_top

// File: verif/pmc_top_tb.sv
// Self-checking testbench for the power mode control block
`timescale 1ns/1ps
module pmc_top_tb;
	// ****************************************
	// Signals and design instance
	// ****************************************
	localparam int W0 = 4;
	localparam int W4 = 20;
	logic        clk_sys_in     = 1'b0;
	logic        rstn_in        = 1'b0;
	logic        psel_in        = 1'b0;
	logic        penable_in     = 1'b0;
	logic        pwrite_in      = 1'b0;
	logic [11:0] paddr_in       = 12'h000;
	logic [31:0] pwdata_in      = 32'h0000_0000;
	logic        sleep_in       = 1'b0;
	logic        wake_in        = 1'b0;
	logic        timer_a_src_in = 1'b0;
	logic        tb1_req_in     = 1'b0;
	logic        line3_in       = 1'b1;
	logic        line7_in       = 1'b1;
	logic        tmy_in         = 1'b1;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic [2:0]  mode_out;
	logic        cpu_run_out;
	logic        sub_tick_out;
	logic [7:0]  pullup5_out;
	logic        tb1_irq_out;
	logic        dt_irq_out;
	logic        line3_evt_out;
	logic        line7_evt_out;
	logic        tmy_evt_out;
	int          n_mismatch     = 0;
	int          comparisons    = 0;
	logic [31:0] q;
	logic        err;

	// Short waits keep the standby exits to a few dozen cycles
	pmc_top #(.WAIT_0(W0), .WAIT_1(6), .WAIT_2(8), .WAIT_3(10), .WAIT_4(W4)) DUT (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .sleep_in(sleep_in), .wake_in(wake_in),
		.timer_a_src_in(timer_a_src_in), .tb1_req_in(tb1_req_in), .line3_in(line3_in),
		.line7_in(line7_in), .tmy_in(tmy_in), .mode_out(mode_out), .cpu_run_out(cpu_run_out),
		.sub_tick_out(sub_tick_out), .pullup5_out(pullup5_out), .tb1_irq_out(tb1_irq_out),
		.dt_irq_out(dt_irq_out), .line3_evt_out(line3_evt_out), .line7_evt_out(line7_evt_out),
		.tmy_evt_out(tmy_evt_out)
	);

	// 25 MHz system clock
	always #20 clk_sys_in = ~clk_sys_in;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A wait that runs out counts as a mismatch and ends the run
	task automatic hang();
		n_mismatch++;
		close_out();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
	endtask

	task automatic do_reset();
		@(posedge clk_sys_in);
		rstn_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
	endtask

	// APB transfer: request held until pready is seen with penable high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		psel_in   <= 1'b1;
		pwrite_in <= wr;
		paddr_in  <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) hang();
		q   = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
		#1; // Callers then see what this edge launched
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask

	function automatic logic [31:0] sc1(input logic ss, input logic [2:0] sts, input logic ls);
		return {24'h000000, ss, sts, ls, 3'h0};
	endfunction

	function automatic logic [31:0] sc2(input logic ns, input logic dt, input logic ms, input logic [1:0] sa);
		return {27'h0, ns, dt, ms, sa};
	endfunction

	// Program both control registers, set timer A source, then issue one sleep pulse
	task automatic sl(input logic [31:0] s1, input logic [31:0] s2, input logic tma, input logic [2:0] em);
		wr(pmc_pkg::PMC_ADDR_SYSCTL1, s1);
		wr(pmc_pkg::PMC_ADDR_SYSCTL2, s2);
		@(posedge clk_sys_in);
		timer_a_src_in <= tma;
		@(posedge clk_sys_in);
		sleep_in <= 1'b1;
		@(posedge clk_sys_in);
		sleep_in <= 1'b0;
		#1;
		chk(mode_out, em);
	endtask

	// Hold wake until the CPU runs; exit cycle count must fall in lo..hi
	task automatic wk(input logic [2:0] em, input int lo, input int hi);
		int n;
		@(posedge clk_sys_in);
		wake_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end while (cpu_run_out !== 1'b1 && n < 400);
		if (n >= 400) hang();
		chk(mode_out, em);
		chk(n >= lo && n <= hi, 1);
		@(posedge clk_sys_in);
		wake_in <= 1'b0;
	endtask

	// Drive one pin and count the events it produces over w cycles
	task automatic pin(input int p, input logic v, input int e, input int w);
		int c;
		@(posedge clk_sys_in);
		case (p)
			0: line3_in <= v;
			1: line7_in <= v;
			default: tmy_in <= v;
		endcase
		c = 0;
		repeat (w) begin
			@(posedge clk_sys_in);
			#1;
			if ((p == 0 && line3_evt_out === 1'b1) || (p == 1 && line7_evt_out === 1'b1) ||
			    (p == 2 && tmy_evt_out === 1'b1)) c++;
		end
		chk(c, e);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rchk(pmc_pkg::PMC_ADDR_PULLUP5, 32'h0000_0000);
		rchk(pmc_pkg::PMC_ADDR_SYSCTL1, 32'h0000_0007);
		rchk(pmc_pkg::PMC_ADDR_SYSCTL2, 32'h0000_00e0);
		apb(1'b0, 12'h01c, 32'h0000_0000);
		chk({q[30:0], err}, 32'h0000_0001);
		wr(pmc_pkg::PMC_ADDR_PULLUP5, 32'h0000_00a5);
		rchk(pmc_pkg::PMC_ADDR_PULLUP5, 32'h0000_00a5);
		wr(pmc_pkg::PMC_ADDR_PULLUP5, 32'h0000_005a);
		chk(pullup5_out, 32'h0000_005a);
	endtask

	task automatic t_sleep();
		sl(sc1(0, 0, 0), sc2(0, 0, 0, 0), 0, pmc_pkg::PMC_SLEEP);
		wk(pmc_pkg::PMC_HIGH, 1, 300);
		sl(sc1(0, 0, 0), sc2(0, 0, 1, 0), 0, pmc_pkg::PMC_SLEEP);
		wk(pmc_pkg::PMC_MEDIUM, 1, 300);
		sl(sc1(1, 0, 0), sc2(0, 0, 0, 0), 0, pmc_pkg::PMC_STANDBY);
		wk(pmc_pkg::PMC_HIGH, W0, W0 + 2);
		sl(sc1(1, 3'b110, 0), sc2(0, 0, 1, 0), 1, pmc_pkg::PMC_WATCH);
		wk(pmc_pkg::PMC_MEDIUM, W4, W4 + 2);
	endtask

	// Starts in medium speed; walks every direct move and the flag
	task automatic t_direct();
		wr(pmc_pkg::PMC_ADDR_IRQEN, 32'h0000_0000);
		sl(sc1(0, 0, 0), sc2(0, 1, 0, 0), 0, pmc_pkg::PMC_HIGH);
		rchk(pmc_pkg::PMC_ADDR_FLAG, 32'h0000_0001);
		chk(dt_irq_out, 0);
		wr(pmc_pkg::PMC_ADDR_IRQEN, 32'h0000_0002);
		chk(dt_irq_out, 1);
		wr(pmc_pkg::PMC_ADDR_FLAG, 32'h0000_0000);
		rchk(pmc_pkg::PMC_ADDR_FLAG, 32'h0000_0000);
		chk(dt_irq_out, 0);
		sl(sc1(0, 0, 0), sc2(0, 1, 1, 0), 0, pmc_pkg::PMC_MEDIUM);
		sl(sc1(1, 0, 1), sc2(0, 1, 0, 0), 1, pmc_pkg::PMC_SUBACT);
		for (int sa = 0; sa < 4; sa++) begin
			int c;
			wr(pmc_pkg::PMC_ADDR_SYSCTL2, sc2(0, 1, 0, sa[1:0]));
			repeat (8) @(posedge clk_sys_in);
			c = 0;
			repeat (64) begin
				@(posedge clk_sys_in);
				#1;
				if (sub_tick_out === 1'b1) c++;
			end
			chk(c, sa == 0 ? 8 : (sa == 1 ? 16 : 32));
		end
		sl(sc1(1, 0, 0), sc2(0, 1, 1, 0), 1, pmc_pkg::PMC_MEDIUM);
		sl(sc1(1, 0, 1), sc2(0, 1, 1, 0), 1, pmc_pkg::PMC_SUBACT);
		sl(sc1(1, 0, 0), sc2(0, 1, 0, 0), 1, pmc_pkg::PMC_HIGH);
		sl(sc1(1, 0, 1), sc2(0, 1, 0, 0), 1, pmc_pkg::PMC_SUBACT);
		sl(sc1(0, 0, 0), sc2(0, 0, 0, 0), 0, pmc_pkg::PMC_SUBSLEEP);
		rchk(pmc_pkg::PMC_ADDR_MODE, 32'h0000_000c);
		wk(pmc_pkg::PMC_SUBACT, 1, 1);
	endtask

	// After a fresh reset: direct move to subactive, then with direct off subactive to watch
	task automatic t_subwatch();
		sl(sc1(1, 0, 1), sc2(0, 1, 0, 0), 1, pmc_pkg::PMC_SUBACT);
		sl(sc1(1, 0, 1), sc2(0, 0, 0, 0), 1, pmc_pkg::PMC_WATCH);
	endtask

	task automatic t_tb1();
		@(posedge clk_sys_in);
		tb1_req_in <= 1'b1;
		wr(pmc_pkg::PMC_ADDR_IRQEN, 32'h0000_0000);
		chk(tb1_irq_out, 0);
		wr(pmc_pkg::PMC_ADDR_IRQEN, 32'h0000_0001);
		chk(tb1_irq_out, 1);
	endtask

	// Pins idle high; falling then rising selection on all three inputs
	task automatic t_pins();
		wr(pmc_pkg::PMC_ADDR_EDGE, 32'h0000_0000);
		for (int p = 0; p < 3; p++) begin
			pin(p, 1'b0, 1, 120);
			pin(p, 1'b1, 0, 120);
		end
		wr(pmc_pkg::PMC_ADDR_EDGE, 32'h0000_0003);
		for (int p = 0; p < 3; p++) begin
			pin(p, 1'b0, 0, 120);
			pin(p, 1'b1, 1, 120);
		end
		wr(pmc_pkg::PMC_ADDR_SYSCTL2, sc2(1, 0, 0, 0));
		pin(0, 1'b0, 0, 30);
		pin(0, 1'b1, 1, 6);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset();
		t_regs();
		t_sleep();
		t_direct();
		do_reset();
		t_subwatch();
		do_reset();
		t_tb1();
		t_pins();
		close_out();
	end
endmodule // pmc_top_tb
